// ===== pnic_pkg.sv
package pnic_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the management bus
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_EXPANSION = 5'h06;
  localparam logic [4:0] OFF_NEXT_PAGE_TRANSMIT = 5'h07;
  localparam logic [4:0] OFF_PARTNER_NEXT_PAGE_ABILITY = 5'h08;
  localparam logic [4:0] OFF_RECEIVE_ERROR_TALLY = 5'h15;
  localparam logic [4:0] OFF_INTERRUPT_CONTROL_STATUS = 5'h1b;
  localparam logic [4:0] OFF_PHY_SPECIAL_CONTROL = 5'h1f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NP_MORE_POS = 15;
  localparam int NP_MSG_PAGE_POS = 13;
  localparam int NP_ACK2_POS = 12;
  localparam int NP_TOGGLE_POS = 11;
  localparam int EXP_PARTNER_AN_POS = 0;
  localparam int CTL_XOVER_DIS_POS = 13;
  localparam int CTL_ENERGY_POS = 12;
  localparam int CTL_FORCE_LINK_POS = 11;
  localparam int CTL_POWER_SAVE_POS = 10;
  localparam int CTL_INT_LEVEL_POS = 9;
  localparam int CTL_JABBER_EN_POS = 8;
  localparam int CTL_AN_DONE_POS = 7;
  localparam int CTL_PAUSE_POS = 6;
  localparam int CTL_ISOLATE_POS = 5;
  localparam int CTL_SQE_POS = 1;
  localparam int CTL_SCRAMBLE_OFF_POS = 0;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] NP_TX_RESET = 16'h2001;
  localparam logic [15:0] NP_TX_WMASK = 16'hb7ff;
  localparam logic [15:0] CTL_RESET = 16'h0500;
  localparam logic [15:0] CTL_WMASK = 16'h2f03;
  localparam logic [7:0] INT_EN_RESET = 8'h00;
  localparam logic [15:0] TALLY_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Management frame figures
  // ----------------------------------------------------------------
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [3:0] HEADER_BITS = 4'he;
  localparam logic [3:0] DATA_LAST = 4'hf;
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  typedef enum logic [2:0] {
    ST_PRE = 3'b000,
    ST_HDR = 3'b001,
    ST_TA1 = 3'b010,
    ST_TA2 = 3'b011,
    ST_DATA = 3'b100
  } pnic_state_e;

endpackage : pnic_pkg

// ===== pnic_regs.sv
// Behaviour
// [R1] Next-page bit 15 is writable: more pages follow when set; resets zero.
// [R2] Next-page bit 13 writable selects message page; resets to one.
// [R3] Next-page bit 12 writable: will comply with message; resets zero.
// [R4] Next-page bit 11 is read-only toggle of previous transmitted code word.
// [R5] Next-page bits 10:0 are a writable message code, reset value 001.
// [R6] Partner next-page bits 15:12 and message code are read-only, reset zero.
// [R7] Partner toggle reads the inverse of the previously transmitted toggle.
// [R8] Expansion bit 0 read-only shows partner auto-negotiation ability, reset zero.
// [R9] Read-only 16-bit tally counts receive-error packets, reset 0000.
// [R10] Interrupt register upper byte holds eight writable enables, reset zero.
// [R11] Interrupt register lower byte holds eight self-clearing event flags.
// [R12] Polarity bit makes interrupt output active high when set, default low.
// [R13] Writable bit disables automatic crossover when set, default zero.
// [R14] Read-only bit shows signal energy present on the receive pair.
// [R15] Forced-link bit lets the transmitter send without a valid link.
// [R16] Writable power-saving enable bit, reset value one.
// [R17] Writable jabber counter enable bit, default enabled.
// [R18] Control bit 7 reports auto-negotiation completion, reset zero.
// [R19] Read-only bit reports negotiated flow-control result.
// [R20] Read-only bit shows the transceiver is in isolate mode.
// [R21] Writable SQE test enable bit, default disabled.
// [R22] Writable bit bypasses the transmit scrambler, default scrambling on.
// [R23] Interrupt asserts while any enabled flag is set; flags clear on read.
module pnic_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // Management pins
  input wire logic MDC_IN,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE_OUT,
  // Status from the transceiver core
  input wire logic [7:0] EVENT_IN,
  input wire logic RX_ERR_PKT_IN,
  input wire logic TX_TOGGLE_IN,
  input wire logic [15:0] PARTNER_PAGE_IN,
  input wire logic PARTNER_AN_ABLE_IN,
  input wire logic ENERGY_IN,
  input wire logic AN_DONE_IN,
  input wire logic PAUSE_RESULT_IN,
  input wire logic ISOLATE_IN,
  // Controls to the transceiver core
  output logic [15:0] NEXT_PAGE_TX_OUT,
  output logic XOVER_DIS_OUT,
  output logic FORCE_LINK_OUT,
  output logic POWER_SAVE_OUT,
  output logic JABBER_EN_OUT,
  output logic SQE_TEST_OUT,
  output logic SCRAMBLE_OFF_OUT,
  // Interrupt pin
  output logic INT_OUT
);

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  function automatic logic pnic_hit(input logic [4:0] addr, input logic [4:0] off);
    pnic_hit = (addr == off);
  endfunction : pnic_hit

  // ----------------------------------------------------------------
  // Pin synchronisers and clock edge enable
  // ----------------------------------------------------------------
  logic mdc_s1;
  logic mdc_s2;
  logic mdc_s3;
  logic mdio_s1;
  logic mdio_s2;

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end
    else
    begin
      mdc_s1 <= MDC_IN;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= MDIO_IN;
      mdio_s2 <= mdio_s1;
    end
  end

  // The serial clock is far slower than the core, so one enable per rising edge is enough.
  wire mdc_rise = mdc_s2 & ~mdc_s3;
  wire bit_in = mdio_s2;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] np_tx;
  logic [15:0] ctl;
  logic [7:0] int_en;
  logic [7:0] int_flag;
  logic [15:0] tally;

  // ----------------------------------------------------------------
  // Frame engine state
  // ----------------------------------------------------------------
  pnic_pkg::pnic_state_e state;
  logic [5:0] pre_cnt;
  logic [3:0] bit_cnt;
  // Only the direction and register address outlive a header; the rest is decoded on the fly.
  logic [12:0] hdr;
  logic [15:0] shreg;
  logic is_read;
  logic [4:0] reg_addr;

  wire [13:0] hdr_next = {hdr, bit_in};
  // The start bit 0 is taken while hunting the preamble, so the header ends on the thirteenth
  // edge in this state, the one that carries the last register address bit.
  wire hdr_done = (state == pnic_pkg::ST_HDR) && (bit_cnt == pnic_pkg::HEADER_BITS - 4'h2);
  wire hdr_start_ok = (hdr_next[13:12] == pnic_pkg::FRAME_START);
  wire hdr_rd = (hdr_next[11:10] == pnic_pkg::OP_READ);
  wire hdr_wr = (hdr_next[11:10] == pnic_pkg::OP_WRITE);
  wire hdr_mine = (hdr_next[9:5] == PHY_ADDR);
  wire hdr_ok = hdr_start_ok & (hdr_rd | hdr_wr) & hdr_mine;
  wire [4:0] hdr_reg = hdr_next[4:0];

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Toggle and status bits come straight from the core, so writes can never reach them.
  wire [15:0] np_tx_view = {np_tx[15:12], TX_TOGGLE_IN, np_tx[10:0]}; // [R4]
  wire [15:0] partner_view = {PARTNER_PAGE_IN[15:12], ~TX_TOGGLE_IN, PARTNER_PAGE_IN[10:0]}; // [R6] [R7]
  wire [15:0] expansion_view = {15'h0000, PARTNER_AN_ABLE_IN}; // [R8]
  wire [15:0] int_view = {int_en, int_flag}; // [R10] [R11]
  wire [15:0] status_bits = {3'h0, ENERGY_IN, 4'h0, AN_DONE_IN, PAUSE_RESULT_IN, ISOLATE_IN, 5'h00}; // [R14] [R18] [R19] [R20]
  wire [15:0] ctl_view = (ctl & pnic_pkg::CTL_WMASK) | status_bits;

  wire [15:0] read_word =
    pnic_hit(hdr_reg, pnic_pkg::OFF_EXPANSION) ? expansion_view :
    pnic_hit(hdr_reg, pnic_pkg::OFF_NEXT_PAGE_TRANSMIT) ? np_tx_view :
    pnic_hit(hdr_reg, pnic_pkg::OFF_PARTNER_NEXT_PAGE_ABILITY) ? partner_view :
    pnic_hit(hdr_reg, pnic_pkg::OFF_RECEIVE_ERROR_TALLY) ? tally : // [R9]
    pnic_hit(hdr_reg, pnic_pkg::OFF_INTERRUPT_CONTROL_STATUS) ? int_view :
    pnic_hit(hdr_reg, pnic_pkg::OFF_PHY_SPECIAL_CONTROL) ? ctl_view :
    16'h0000;

  // Unmapped offsets read as zero; writes to them are dropped.
  wire start_read = mdc_rise & hdr_done & hdr_ok & hdr_rd;
  // Flags clear as the read header passes, after the snapshot, so the read still sees them.
  wire flag_clear = start_read & pnic_hit(hdr_reg, pnic_pkg::OFF_INTERRUPT_CONTROL_STATUS); // [R23]

  wire data_end = mdc_rise && (state == pnic_pkg::ST_DATA) && (bit_cnt == pnic_pkg::DATA_LAST);
  wire do_write = data_end & ~is_read;
  wire [15:0] wdata = {shreg[14:0], bit_in};

  wire wr_np = do_write & pnic_hit(reg_addr, pnic_pkg::OFF_NEXT_PAGE_TRANSMIT);
  wire wr_int = do_write & pnic_hit(reg_addr, pnic_pkg::OFF_INTERRUPT_CONTROL_STATUS);
  wire wr_ctl = do_write & pnic_hit(reg_addr, pnic_pkg::OFF_PHY_SPECIAL_CONTROL);

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  pnic_pkg::pnic_state_e next_state;
  logic [5:0] next_pre_cnt;

  // Any zero before thirty-two ones restarts the hunt, since every frame needs a full preamble.
  always_comb
  begin
    next_state = state;
    next_pre_cnt = pre_cnt;
    case (state)
      pnic_pkg::ST_PRE:
      begin
        if (bit_in)
        begin
          next_pre_cnt = (pre_cnt == pnic_pkg::PREAMBLE_ONES) ? pre_cnt : pre_cnt + 6'h01;
        end
        else
        begin
          next_pre_cnt = 6'h00;
          if (pre_cnt == pnic_pkg::PREAMBLE_ONES)
          begin
            next_state = pnic_pkg::ST_HDR;
          end
        end
      end
      pnic_pkg::ST_HDR:
      begin
        if (hdr_done)
        begin
          next_state = hdr_ok ? pnic_pkg::ST_TA1 : pnic_pkg::ST_PRE;
        end
      end
      pnic_pkg::ST_TA1:
      begin
        next_state = pnic_pkg::ST_TA2;
      end
      pnic_pkg::ST_TA2:
      begin
        next_state = pnic_pkg::ST_DATA;
      end
      pnic_pkg::ST_DATA:
      begin
        if (bit_cnt == pnic_pkg::DATA_LAST)
        begin
          next_state = pnic_pkg::ST_PRE;
        end
      end
      default:
      begin
        next_state = pnic_pkg::ST_PRE;
        next_pre_cnt = 6'h00;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state <= pnic_pkg::ST_PRE;
      pre_cnt <= 6'h00;
      bit_cnt <= 4'h0;
      hdr <= 13'h0000;
      is_read <= 1'b0;
      reg_addr <= 5'h00;
    end
    else if (mdc_rise)
    begin
      state <= next_state;
      pre_cnt <= next_pre_cnt;
      hdr <= hdr_next[12:0];
      bit_cnt <= (state == next_state) ? bit_cnt + 4'h1 : 4'h0;
      if (hdr_done)
      begin
        is_read <= hdr_rd;
        reg_addr <= hdr_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial data shifter and pin drive
  // ----------------------------------------------------------------
  // Output changes right after the rising edge, giving the station a full clock period of setup.
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      shreg <= 16'h0000;
      MDIO_OUT <= 1'b1;
      MDIO_OE_OUT <= 1'b0;
    end
    else if (mdc_rise)
    begin
      if (start_read)
      begin
        shreg <= read_word;
      end
      else if (state == pnic_pkg::ST_TA1 && is_read)
      begin
        MDIO_OE_OUT <= 1'b1;
        MDIO_OUT <= 1'b0;
      end
      else if (state == pnic_pkg::ST_TA2 && is_read)
      begin
        MDIO_OUT <= shreg[15];
        shreg <= {shreg[14:0], 1'b0};
      end
      else if (state == pnic_pkg::ST_DATA)
      begin
        if (is_read)
        begin
          MDIO_OUT <= (bit_cnt == pnic_pkg::DATA_LAST) ? 1'b1 : shreg[15];
          MDIO_OE_OUT <= (bit_cnt != pnic_pkg::DATA_LAST);
          shreg <= {shreg[14:0], 1'b0};
        end
        else
        begin
          shreg <= wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Read-only bits are masked off on the way in, so a write never disturbs them.
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      np_tx <= pnic_pkg::NP_TX_RESET; // [R1] [R2] [R3] [R5]
      ctl <= pnic_pkg::CTL_RESET; // [R16] [R17] [R21] [R22]
      int_en <= pnic_pkg::INT_EN_RESET;
    end
    else
    begin
      if (wr_np)
      begin
        np_tx <= wdata & pnic_pkg::NP_TX_WMASK; // [R1] [R2] [R3] [R5]
      end
      if (wr_ctl)
      begin
        ctl <= wdata & pnic_pkg::CTL_WMASK; // [R12] [R13] [R15] [R16] [R17] [R21] [R22]
      end
      if (wr_int)
      begin
        int_en <= wdata[15:8]; // [R10]
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags, error tally and interrupt pin
  // ----------------------------------------------------------------
  // A new event in the clearing cycle survives, so no event is lost to a read.
  wire [7:0] next_int_flag = (flag_clear ? 8'h00 : int_flag) | EVENT_IN; // [R11] [R23]
  wire int_active = |(int_flag & int_en); // [R23]

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      int_flag <= 8'h00;
      tally <= pnic_pkg::TALLY_RESET;
      INT_OUT <= 1'b1;
    end
    else
    begin
      int_flag <= next_int_flag;
      // The tally holds at its top value rather than wrapping back to a small count.
      if (RX_ERR_PKT_IN && tally != 16'hffff)
      begin
        tally <= tally + 16'h0001; // [R9]
      end
      INT_OUT <= ctl[pnic_pkg::CTL_INT_LEVEL_POS] ? int_active : ~int_active; // [R12] [R23]
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // These copies lag the register by one core cycle, which keeps every output on a flip-flop.
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      NEXT_PAGE_TX_OUT <= pnic_pkg::NP_TX_RESET;
      XOVER_DIS_OUT <= 1'b0;
      FORCE_LINK_OUT <= 1'b0;
      POWER_SAVE_OUT <= 1'b1;
      JABBER_EN_OUT <= 1'b1;
      SQE_TEST_OUT <= 1'b0;
      SCRAMBLE_OFF_OUT <= 1'b0;
    end
    else
    begin
      NEXT_PAGE_TX_OUT <= np_tx;
      XOVER_DIS_OUT <= ctl[pnic_pkg::CTL_XOVER_DIS_POS]; // [R13]
      FORCE_LINK_OUT <= ctl[pnic_pkg::CTL_FORCE_LINK_POS]; // [R15]
      POWER_SAVE_OUT <= ctl[pnic_pkg::CTL_POWER_SAVE_POS]; // [R16]
      JABBER_EN_OUT <= ctl[pnic_pkg::CTL_JABBER_EN_POS]; // [R17]
      SQE_TEST_OUT <= ctl[pnic_pkg::CTL_SQE_POS]; // [R21]
      SCRAMBLE_OFF_OUT <= ctl[pnic_pkg::CTL_SCRAMBLE_OFF_POS]; // [R22]
    end
  end

endmodule : pnic_regs

// ===== pnic_regs_sva.sv
module pnic_regs_sva (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // Management pins
  input wire logic MDC_IN,
  input wire logic MDIO_OUT,
  input wire logic MDIO_OE_OUT,
  // Core side
  input wire logic [7:0] EVENT_IN,
  input wire logic [15:0] NEXT_PAGE_TX_OUT,
  input wire logic XOVER_DIS_OUT,
  input wire logic FORCE_LINK_OUT,
  input wire logic POWER_SAVE_OUT,
  input wire logic JABBER_EN_OUT,
  input wire logic SQE_TEST_OUT,
  input wire logic SCRAMBLE_OFF_OUT,
  input wire logic INT_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  wire [5:0] ctl = {XOVER_DIS_OUT, FORCE_LINK_OUT, POWER_SAVE_OUT, JABBER_EN_OUT, SQE_TEST_OUT, SCRAMBLE_OFF_OUT};

  // Eight core cycles with the management clock held low leave room for the commit lag.
  a_reset_page: assert property ($fell(RST_IN) |-> NEXT_PAGE_TX_OUT == 16'h2001)
    else $error("next page word wrong after reset");
  a_reset_ctl: assert property ($fell(RST_IN) |-> ctl == 6'h0c)
    else $error("control outputs wrong after reset");
  a_reset_int: assert property ($fell(RST_IN) |-> INT_OUT && !MDIO_OE_OUT)
    else $error("interrupt or data pin active after reset");
  a_toggle_clear: assert property (NEXT_PAGE_TX_OUT[11] == 1'b0)
    else $error("toggle bit stored in next page word");
  a_ctl_quiet: assert property ((!MDC_IN) [*8] |=> $stable(ctl) && $stable(NEXT_PAGE_TX_OUT))
    else $error("controls changed without bus traffic");
  a_int_quiet: assert property ((EVENT_IN == 8'h00 && !MDC_IN) [*8] |=> $stable(INT_OUT))
    else $error("interrupt changed without cause");
  a_read_steady: assert property (MDIO_OE_OUT |-> $stable(ctl))
    else $error("controls changed during a read");
  a_turn_zero: assert property ($rose(MDIO_OE_OUT) |-> !MDIO_OUT)
    else $error("turnaround bit not zero");
  a_idle_high: assert property (!MDIO_OE_OUT |-> MDIO_OUT)
    else $error("data pin not high when released");
  a_drive_ends: assert property ((!MDC_IN) [*8] |=> !MDIO_OE_OUT)
    else $error("data pin driven outside a frame");

  c_read: cover property ($rose(MDIO_OE_OUT));
  c_int_low: cover property ($fell(INT_OUT));
  c_int_high: cover property ($rose(INT_OUT));
  c_ctl: cover property ($changed(ctl));
endmodule : pnic_regs_sva

// ===== pnic_mac_model.sv
module pnic_mac_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Clock
  input wire logic clk_in,
  // Management pins
  input wire logic mdio_in,
  output logic mdc_out,
  output logic mdio_out,
  output logic mdio_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_oe_out = 1'b0;
  end

  // The clock stands low between frames; read data is taken at each rising edge.
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, pnic_pkg::FRAME_START, op, PHY_ADDR, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--)
    begin
      @(posedge clk_in);
      #1;
      mdc_out = 1'b0;
      mdio_oe_out = (op == pnic_pkg::OP_WRITE) || (i > 17);
      mdio_out = bits[i];
      repeat (4) @(posedge clk_in);
      #1;
      if (i < 16)
        rd[i] = mdio_in;
      mdc_out = 1'b1;
      repeat (3) @(posedge clk_in);
    end
    @(posedge clk_in);
    #1;
    mdc_out = 1'b0;
    mdio_oe_out = 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
  endtask : frame
endmodule : pnic_mac_model

// ===== phy_nextpage_irq_ctrl_regs_tb_top.sv
module phy_nextpage_irq_ctrl_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [5:0] st;
    logic [4:0] ra;
    logic [15:0] wd;
    logic [15:0] rd;
    logic [6:0] pins;
  } pnic_row_s;

  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mdc, mac_out, mac_oe, dut_out, dut_oe, rx_err, int_pin;
  logic [7:0] ev = 8'h00;
  logic [5:0] st = 6'h00;
  logic [5:0] ctl;
  logic [15:0] np;
  logic [15:0] pp = 16'h5a5a;
  logic [15:0] junk;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  // The line has a pull-up, so a released wire reads high.
  wire mdio = dut_oe ? dut_out : (mac_oe ? mac_out : 1'b1);
  pnic_row_s rows [11] = '{
    '{6'h20, 5'h07, 16'hffff, 16'hbfff, 7'h19},
    '{6'h00, 5'h07, 16'h0000, 16'h0000, 7'h19},
    '{6'h20, 5'h08, 16'h0000, 16'h525a, 7'h19},
    '{6'h00, 5'h08, 16'hffff, 16'h5a5a, 7'h19},
    '{6'h10, 5'h06, 16'hffff, 16'h0001, 7'h19},
    '{6'h0f, 5'h1f, 16'hffff, 16'h3fe3, 7'h7e},
    '{6'h00, 5'h1f, 16'h0000, 16'h0000, 7'h01},
    '{6'h00, 5'h15, 16'hffff, 16'h0000, 7'h01},
    '{6'h00, 5'h03, 16'hffff, 16'h0000, 7'h01},
    '{6'h00, 5'h1b, 16'hff00, 16'hff00, 7'h01},
    '{6'h00, 5'h1f, 16'h0500, 16'h0500, 7'h19}
  };

  always #25 clk = ~clk;

  pnic_regs i_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .MDC_IN(mdc), .MDIO_IN(mdio), .MDIO_OUT(dut_out),
    .MDIO_OE_OUT(dut_oe), .EVENT_IN(ev), .RX_ERR_PKT_IN(rx_err), .TX_TOGGLE_IN(st[5]),
    .PARTNER_PAGE_IN(pp), .PARTNER_AN_ABLE_IN(st[4]), .ENERGY_IN(st[3]), .AN_DONE_IN(st[2]),
    .PAUSE_RESULT_IN(st[1]), .ISOLATE_IN(st[0]), .NEXT_PAGE_TX_OUT(np), .XOVER_DIS_OUT(ctl[5]),
    .FORCE_LINK_OUT(ctl[4]), .POWER_SAVE_OUT(ctl[3]), .JABBER_EN_OUT(ctl[2]), .SQE_TEST_OUT(ctl[1]),
    .SCRAMBLE_OFF_OUT(ctl[0]), .INT_OUT(int_pin));
  pnic_mac_model i_mac (.clk_in(clk), .mdio_in(mdio), .mdc_out(mdc), .mdio_out(mac_out), .mdio_oe_out(mac_oe));

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_pins(input logic [6:0] got, input logic [6:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pins

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    i_mac.frame(pnic_pkg::OP_WRITE, ra, wd, d);
  endtask : wr

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] d;
    i_mac.frame(pnic_pkg::OP_READ, ra, 16'h0000, d);
    chk_word(d, exp);
  endtask : rd_chk

  task automatic do_reset();
    rst = 1'b1;
    st = 6'h00;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk_pins({ctl, int_pin}, 7'h19);
    chk_word(np, 16'h2001);
    rd_chk(5'h07, 16'h2001);
    rd_chk(5'h1f, 16'h0500);
    rd_chk(5'h1b, 16'h0000);
    rd_chk(5'h15, 16'h0000);
    rd_chk(5'h06, 16'h0000);
  endtask : do_reset

  task automatic end_sim();
    if ((err_count == 0) && (checks > 0))
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    rx_err = 1'b0;
    do_reset();
    foreach (rows[k])
    begin
      st = rows[k].st;
      wr(rows[k].ra, rows[k].wd);
      rd_chk(rows[k].ra, rows[k].rd);
      chk_pins({ctl, int_pin}, rows[k].pins);
    end
    wr(5'h07, 16'hffff);
    chk_word(np, 16'hb7ff);
    i_mac.frame(2'h3, 5'h07, 16'h0000, junk);
    rd_chk(5'h07, 16'hb7ff);
    pp = 16'ha5a5;
    rd_chk(5'h08, 16'hada5);
    wr(5'h1b, 16'h4000);
    for (int i = 0; i < 8; i++)
    begin
      ev = 8'h01 << i;
      @(posedge clk);
      #1;
      ev = 8'h00;
      repeat (3) @(posedge clk);
      #1;
      chk_pins({ctl, int_pin}, {6'h0c, i != 6});
      rd_chk(5'h1b, 16'h4000 | (16'h0001 << i));
      chk_pins({ctl, int_pin}, 7'h19);
    end
    ev = 8'h40;
    @(posedge clk);
    #1;
    ev = 8'h00;
    wr(5'h1f, 16'h0700);
    chk_pins({ctl, int_pin}, 7'h19);
    rd_chk(5'h1b, 16'h4040);
    chk_pins({ctl, int_pin}, 7'h18);
    rx_err = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rx_err = 1'b0;
    rd_chk(5'h15, 16'h0003);
    do_reset();
    end_sim();
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_count++;
      end_sim();
    end
  end
endmodule : phy_nextpage_irq_ctrl_regs_tb_top

bind pnic_regs pnic_regs_sva i_sva (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .MDC_IN(MDC_IN),
  .MDIO_OUT(MDIO_OUT), .MDIO_OE_OUT(MDIO_OE_OUT), .EVENT_IN(EVENT_IN), .NEXT_PAGE_TX_OUT(NEXT_PAGE_TX_OUT),
  .XOVER_DIS_OUT(XOVER_DIS_OUT), .FORCE_LINK_OUT(FORCE_LINK_OUT), .POWER_SAVE_OUT(POWER_SAVE_OUT),
  .JABBER_EN_OUT(JABBER_EN_OUT), .SQE_TEST_OUT(SQE_TEST_OUT), .SCRAMBLE_OFF_OUT(SCRAMBLE_OFF_OUT),
  .INT_OUT(INT_OUT));
